// >>> hdl/spci_regs.svh
`ifndef SPCI_REGS_SVH
`define SPCI_REGS_SVH

// Register byte offsets
`define SPCI_OFS_CTRL 8'h00
`define SPCI_OFS_CFG 8'h04
`define SPCI_OFS_CMD_PPR 8'h08
`define SPCI_OFS_OUT_PPR 8'h0C
`define SPCI_OFS_TORQUE 8'h10
`define SPCI_OFS_DEV_THR 8'h14
`define SPCI_OFS_POL_OBJ 8'h18
`define SPCI_OFS_STATUS 8'h1C
`define SPCI_OFS_MASK 8'h20
`define SPCI_OFS_CMD_POS 8'h24
`define SPCI_OFS_ACTIVE 8'h28
`define SPCI_OFS_TLIM 8'h2C

// Field positions
`define SPCI_CTRL_APPLY 0
`define SPCI_ST_DEV 0
`define SPCI_ST_OVS 1
`define SPCI_TQ_OBJ_LSB 16

// Reset values
`define SPCI_RST_DIR_INV 1'h0
`define SPCI_RST_FIELD 2'h3
`define SPCI_RST_MODE 4'h9
`define SPCI_RST_CMD_PPR 24'h000000
`define SPCI_RST_OUT_PPR 16'h09C4
`define SPCI_RST_OUTB 1'h0
`define SPCI_RST_TORQUE1 10'h12C
`define SPCI_RST_TORQUE_OBJ 10'h1F4
`define SPCI_RST_DEV_THR 9'h01E

// Limits and codes
`define SPCI_TORQUE1_MAX 10'h1F4
`define SPCI_DEV_THR_MAX 9'h1F4
`define SPCI_CMD_PPR_MAX 24'h800000
`define SPCI_PPR_FALLBACK 24'h002710
`define SPCI_FB_CPR 24'h020000
`define SPCI_ACC_SAT 24'hF00000
`define SPCI_MODE_FIELDBUS 4'h9
`define SPCI_FMT_QUAD0 2'h0
`define SPCI_FMT_CW 2'h1
`define SPCI_FMT_QUAD2 2'h2
`define SPCI_FMT_PDIR 2'h3

// Timing: output edge rate ceiling
`define SPCI_CLK_HZ 10000000
`define SPCI_OUT_EDGE_MAX_HZ 1000000
`define SPCI_OUT_EDGE_GAP ((`SPCI_CLK_HZ + `SPCI_OUT_EDGE_MAX_HZ - 1) / `SPCI_OUT_EDGE_MAX_HZ)

`endif

// >>> hdl/spci_pkg.sv
package spci_pkg;

  typedef struct packed {
    logic dir_inv;
    logic [1:0] field;
    logic [3:0] mode;
    logic [23:0] cmd_ppr;
    logic [15:0] out_ppr;
    logic outb;
  } spci_cfg_type;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] filt;
    logic [31:0] cmd_pos;
    spci_cfg_type stg;
    spci_cfg_type act;
    logic pol_obj;
    logic [9:0] torque1;
    logic [9:0] torque_obj;
    logic [9:0] torque_eff;
    logic [8:0] dev_thr;
    logic [1:0] status;
    logic [1:0] mask;
    logic [23:0] enc_acc;
    logic [1:0] enc_cnt;
    logic enc_a;
    logic enc_b;
    logic [3:0] gap;
    logic probe1;
    logic probe2;
    logic [31:0] rdata;
    logic irq;
  } spci_state_type;

endpackage : spci_pkg

// >>> hdl/spci_top.sv
// Contract
// - Direction inversion 0 follows the command polarity and 1 turns the motor the other way.
// - The fieldbus polarity object acts only while direction inversion is 0.
// - Probe field 0 inverts both probes, 1 probe 2, 2 probe 1, 3 neither.
// - The shared field is probe polarity in control mode 9, else the pulse input format.
// - Format 0 or 2 is quadrature, 1 is CW/CCW trains, 3 is pulse plus direction.
// - Quadrature counts four per cycle and single-phase formats count one per pulse.
// - Emulated encoder counts per revolution are the output setting times four.
// - Output edge rate above 1MHz may raise the output overspeed alarm.
// - Output logic 0 leaves phase B as is and 1 inverts it.
// - Effective torque limit is the smaller of the first limit and the fieldbus maximum.
// - The first torque limit is a percent of rated current, at most 500, default 300.
// - Deviation beyond threshold times 0.1rev raises the excess deviation alarm.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "spci_regs.svh"

module spci_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Command pulse and probe pins
  input wire logic cmd_a_pin,
  input wire logic cmd_b_pin,
  input wire logic probe1_pin,
  input wire logic probe2_pin,
  // Motor feedback, same clock
  input wire logic fb_step,
  input wire logic fb_dir,
  input wire logic [31:0] fb_pos,
  // Drive outputs
  output logic [31:0] cmd_pos,
  output logic [9:0] torque_limit_eff,
  output logic enc_a_out,
  output logic enc_b_out,
  output logic probe1_level,
  output logic probe2_level
);

  spci_pkg::spci_state_type s_ff;
  spci_pkg::spci_state_type nxt_s;
  logic [3:0] filt_nxt;
  logic step_en;
  logic step_neg;
  logic flip;
  logic [1:0] g_old;
  logic [1:0] g_new;
  logic [1:0] g_diff;
  logic a_rise;
  logic b_rise;
  logic enc_edge;
  logic ovs_evt;
  logic dev_evt;
  logic [31:0] dev;
  logic [31:0] dev_mag;
  logic [23:0] rev_counts;
  logic [39:0] dev_lhs;
  logic [39:0] dev_rhs;
  logic [23:0] acc_add;
  logic [1:0] st_evt;
  logic [1:0] st_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter: a change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      assign filt_nxt[gi] = (s_ff.sync2[gi] == s_ff.sync3[gi]) ? s_ff.sync3[gi] : s_ff.filt[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = {probe2_pin, probe1_pin, cmd_b_pin, cmd_a_pin};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.sync3 = s_ff.sync2;
    nxt_s.filt = filt_nxt;

    a_rise = filt_nxt[0] & ~s_ff.filt[0];
    b_rise = filt_nxt[1] & ~s_ff.filt[1];
    g_old = {s_ff.filt[0], s_ff.filt[0] ^ s_ff.filt[1]};
    g_new = {filt_nxt[0], filt_nxt[0] ^ filt_nxt[1]};
    g_diff = g_new - g_old;
    step_en = 1'b0;
    step_neg = 1'b0;
    case (s_ff.act.field)
      `SPCI_FMT_QUAD0, `SPCI_FMT_QUAD2: begin
        // A skipped gray step is a glitch and is dropped
        step_en = (g_diff == 2'h1) || (g_diff == 2'h3);
        step_neg = (g_diff == 2'h3);
      end
      `SPCI_FMT_CW: begin
        // Coincident CW and CCW edges cancel
        step_en = a_rise ^ b_rise;
        step_neg = b_rise;
      end
      default: begin
        // direction level at the pulse edge
        step_en = a_rise;
        step_neg = filt_nxt[1];
      end
    endcase
    // no pulse input in fieldbus mode
    if (s_ff.act.mode == `SPCI_MODE_FIELDBUS) begin
      step_en = 1'b0;
    end
    flip = s_ff.act.dir_inv ? 1'b1 : s_ff.pol_obj;
    if (step_en) begin
      nxt_s.cmd_pos = (step_neg ^ flip) ? s_ff.cmd_pos - 32'h00000001
                                        : s_ff.cmd_pos + 32'h00000001;
    end

    // probe polarity, only in fieldbus mode
    if (s_ff.act.mode == `SPCI_MODE_FIELDBUS) begin
      nxt_s.probe1 = filt_nxt[2] ^ ((s_ff.act.field == 2'h0) || (s_ff.act.field == 2'h2));
      nxt_s.probe2 = filt_nxt[3] ^ ((s_ff.act.field == 2'h0) || (s_ff.act.field == 2'h1));
    end else begin
      nxt_s.probe1 = filt_nxt[2];
      nxt_s.probe2 = filt_nxt[3];
    end

    // rate accumulator: out_ppr*4 output edges per feedback revolution
    ovs_evt = 1'b0;
    acc_add = fb_step ? {6'h00, s_ff.act.out_ppr, 2'h0} : 24'h000000;
    if (s_ff.enc_acc >= `SPCI_ACC_SAT) begin
      // Backlog is running away; drop input rather than wrap
      acc_add = 24'h000000;
      ovs_evt = fb_step;
    end
    enc_edge = (s_ff.enc_acc >= `SPCI_FB_CPR);
    nxt_s.enc_acc = s_ff.enc_acc + acc_add - (enc_edge ? `SPCI_FB_CPR : 24'h000000);
    if (enc_edge) begin
      nxt_s.enc_cnt = fb_dir ? s_ff.enc_cnt - 2'h1 : s_ff.enc_cnt + 2'h1;
      nxt_s.gap = 4'h0;
      // edges closer than the 1MHz spacing; a spacing of exactly the limit is legal
      if (s_ff.gap < 4'(`SPCI_OUT_EDGE_GAP - 1)) begin
        ovs_evt = 1'b1;
      end
    end else if (s_ff.gap < 4'(`SPCI_OUT_EDGE_GAP)) begin
      nxt_s.gap = s_ff.gap + 4'h1;
    end
    nxt_s.enc_a = nxt_s.enc_cnt[1];
    nxt_s.enc_b = nxt_s.enc_cnt[1] ^ nxt_s.enc_cnt[0] ^ s_ff.act.outb;

    // deviation against threshold in tenths of a revolution
    dev = s_ff.cmd_pos - fb_pos;
    dev_mag = dev[31] ? (32'h00000000 - dev) : dev;
    rev_counts = (s_ff.act.cmd_ppr == 24'h000000) ? `SPCI_PPR_FALLBACK : s_ff.act.cmd_ppr;
    dev_lhs = 40'(dev_mag) * 40'h000000000A;
    dev_rhs = 40'(s_ff.dev_thr) * 40'(rev_counts);
    dev_evt = (dev_lhs > dev_rhs);

    nxt_s.torque_eff = (s_ff.torque1 < s_ff.torque_obj) ? s_ff.torque1 : s_ff.torque_obj;

    // Register writes
    st_clr = 2'h0;
    if (reg_wr) begin
      if (reg_addr == `SPCI_OFS_CTRL) begin
        if (reg_wdata[`SPCI_CTRL_APPLY]) begin
          nxt_s.act = s_ff.stg;
        end
      end else if (reg_addr == `SPCI_OFS_CFG) begin
        nxt_s.stg.dir_inv = reg_wdata[0];
        nxt_s.stg.field = reg_wdata[2:1];
        nxt_s.stg.mode = reg_wdata[6:3];
        nxt_s.stg.outb = reg_wdata[7];
      end else if (reg_addr == `SPCI_OFS_CMD_PPR) begin
        nxt_s.stg.cmd_ppr = (reg_wdata[31:0] > 32'(`SPCI_CMD_PPR_MAX)) ? `SPCI_CMD_PPR_MAX
                                                                       : reg_wdata[23:0];
      end else if (reg_addr == `SPCI_OFS_OUT_PPR) begin
        nxt_s.stg.out_ppr = reg_wdata[15:0];
      end else if (reg_addr == `SPCI_OFS_TORQUE) begin
        // first limit capped at 500 percent
        nxt_s.torque1 = (reg_wdata[15:0] > 16'(`SPCI_TORQUE1_MAX)) ? `SPCI_TORQUE1_MAX
                                                                 : reg_wdata[9:0];
        nxt_s.torque_obj = reg_wdata[`SPCI_TQ_OBJ_LSB +: 10];
      end else if (reg_addr == `SPCI_OFS_DEV_THR) begin
        nxt_s.dev_thr = (reg_wdata[15:0] > 16'(`SPCI_DEV_THR_MAX)) ? `SPCI_DEV_THR_MAX
                                                                 : reg_wdata[8:0];
      end else if (reg_addr == `SPCI_OFS_POL_OBJ) begin
        nxt_s.pol_obj = reg_wdata[0];
      end else if (reg_addr == `SPCI_OFS_STATUS) begin
        st_clr = reg_wdata[1:0];
      end else if (reg_addr == `SPCI_OFS_MASK) begin
        nxt_s.mask = reg_wdata[1:0];
      end
    end
    // Set wins over a same-cycle clear so no alarm is lost
    st_evt = 2'h0;
    st_evt[`SPCI_ST_DEV] = dev_evt;
    st_evt[`SPCI_ST_OVS] = ovs_evt;
    nxt_s.status = (s_ff.status & ~st_clr) | st_evt;
    nxt_s.irq = |(nxt_s.status & nxt_s.mask);

    // Register reads, data valid the next cycle only
    nxt_s.rdata = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == `SPCI_OFS_CFG) begin
        nxt_s.rdata = {24'h000000, s_ff.stg.outb, s_ff.stg.mode, s_ff.stg.field,
                       s_ff.stg.dir_inv};
      end else if (reg_addr == `SPCI_OFS_CMD_PPR) begin
        nxt_s.rdata = {8'h00, s_ff.stg.cmd_ppr};
      end else if (reg_addr == `SPCI_OFS_OUT_PPR) begin
        nxt_s.rdata = {16'h0000, s_ff.stg.out_ppr};
      end else if (reg_addr == `SPCI_OFS_TORQUE) begin
        nxt_s.rdata = {6'h00, s_ff.torque_obj, 6'h00, s_ff.torque1};
      end else if (reg_addr == `SPCI_OFS_DEV_THR) begin
        nxt_s.rdata = {23'h000000, s_ff.dev_thr};
      end else if (reg_addr == `SPCI_OFS_POL_OBJ) begin
        nxt_s.rdata = {31'h00000000, s_ff.pol_obj};
      end else if (reg_addr == `SPCI_OFS_STATUS) begin
        nxt_s.rdata = {30'h00000000, s_ff.status};
      end else if (reg_addr == `SPCI_OFS_MASK) begin
        nxt_s.rdata = {30'h00000000, s_ff.mask};
      end else if (reg_addr == `SPCI_OFS_CMD_POS) begin
        nxt_s.rdata = s_ff.cmd_pos;
      end else if (reg_addr == `SPCI_OFS_ACTIVE) begin
        nxt_s.rdata = {24'h000000, s_ff.act.outb, s_ff.act.mode, s_ff.act.field,
                       s_ff.act.dir_inv};
      end else if (reg_addr == `SPCI_OFS_TLIM) begin
        nxt_s.rdata = {22'h000000, s_ff.torque_eff};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.stg.dir_inv <= `SPCI_RST_DIR_INV;
      s_ff.stg.field <= `SPCI_RST_FIELD;
      s_ff.stg.mode <= `SPCI_RST_MODE;
      s_ff.stg.cmd_ppr <= `SPCI_RST_CMD_PPR;
      s_ff.stg.out_ppr <= `SPCI_RST_OUT_PPR;
      s_ff.stg.outb <= `SPCI_RST_OUTB;
      s_ff.act.dir_inv <= `SPCI_RST_DIR_INV;
      s_ff.act.field <= `SPCI_RST_FIELD;
      s_ff.act.mode <= `SPCI_RST_MODE;
      s_ff.act.cmd_ppr <= `SPCI_RST_CMD_PPR;
      s_ff.act.out_ppr <= `SPCI_RST_OUT_PPR;
      s_ff.act.outb <= `SPCI_RST_OUTB;
      s_ff.torque1 <= `SPCI_RST_TORQUE1;
      s_ff.torque_obj <= `SPCI_RST_TORQUE_OBJ;
      s_ff.torque_eff <= `SPCI_RST_TORQUE1;
      s_ff.dev_thr <= `SPCI_RST_DEV_THR;
      s_ff.gap <= 4'(`SPCI_OUT_EDGE_GAP);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata = s_ff.rdata;
  assign irq = s_ff.irq;
  assign cmd_pos = s_ff.cmd_pos;
  assign torque_limit_eff = s_ff.torque_eff;
  assign enc_a_out = s_ff.enc_a;
  assign enc_b_out = s_ff.enc_b;
  assign probe1_level = s_ff.probe1;
  assign probe2_level = s_ff.probe2;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_quad_fwd;
    s_ff.act.mode != `SPCI_MODE_FIELDBUS && s_ff.act.field[0] == 1'b0 && g_diff == 2'h1;
  endsequence

  a_dir_invert: assert property (step_en && s_ff.act.dir_inv |=>
    cmd_pos == $past(cmd_pos) + ($past(step_neg) ? 32'h00000001 : 32'hFFFFFFFF))
    else $error("inverted command moved the wrong way");

  a_obj_priority: assert property (step_en && !s_ff.act.dir_inv |=>
    cmd_pos == $past(cmd_pos) +
    (($past(step_neg) ^ $past(s_ff.pol_obj)) ? 32'hFFFFFFFF : 32'h00000001))
    else $error("polarity object not applied");

  a_probe_pol: assert property (s_ff.act.mode == `SPCI_MODE_FIELDBUS |=>
    probe1_level == ($past(filt_nxt[2]) ^ ($past(s_ff.act.field) inside {2'h0, 2'h2})))
    else $error("probe 1 polarity wrong");

  a_pulse_off: assert property (s_ff.act.mode == `SPCI_MODE_FIELDBUS |=> $stable(cmd_pos))
    else $error("pulse counted in fieldbus mode");

  // one quadrature cycle is four counts
  a_quad_four: assert property (s_quad_fwd |=>
    cmd_pos == $past(cmd_pos) + ($past(flip) ? 32'hFFFFFFFF : 32'h00000001))
    else $error("quadrature count step wrong");

  a_edge_gap: assert property (enc_edge && s_ff.gap < 4'h9 |=> s_ff.status[`SPCI_ST_OVS])
    else $error("overspeed not flagged");

  a_outb_inv: assert property (##1 enc_b_out ==
    (enc_a_out ^ s_ff.enc_cnt[0] ^ $past(s_ff.act.outb)))
    else $error("phase B logic wrong");

  a_torque_min: assert property (##1 torque_limit_eff <= $past(s_ff.torque1) &&
    torque_limit_eff <= $past(s_ff.torque_obj))
    else $error("torque limit above a source");

  a_torque_cap: assert property (s_ff.torque1 <= `SPCI_TORQUE1_MAX)
    else $error("first torque limit above cap");

  // alarm latches and holds until cleared
  a_dev_alarm: assert property (dev_evt |=> s_ff.status[`SPCI_ST_DEV] ##1
    (s_ff.status[`SPCI_ST_DEV] || $past(reg_wr)))
    else $error("deviation alarm lost");

  // active settings change only on restart
  a_restart_only: assert property (!(reg_wr && reg_addr == `SPCI_OFS_CTRL) |=>
    $stable(s_ff.act))
    else $error("settings applied without restart");

  a_pdir_sign: assert property (s_ff.act.field == `SPCI_FMT_PDIR && a_rise && !flip &&
    s_ff.act.mode != `SPCI_MODE_FIELDBUS
    |=> cmd_pos == $past(cmd_pos) + ($past(filt_nxt[1]) ? 32'hFFFFFFFF : 32'h00000001))
    else $error("direction level ignored");

endmodule : spci_top

// >>> tb/spci_ctl_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module spci_ctl_model (
  // Clock
  input wire logic mclk,
  // Command pins, push-pull, held between bursts
  output logic pin_a,
  output logic pin_b
);
  logic [1:0] ph;

  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    ph = 2'h0;
  end

  // Every level is held gap+1 cycles so the input filter never drops it
  task automatic step(input logic a, input logic b, input int gap);
    @(posedge mclk);
    pin_a <= a;
    pin_b <= b;
    repeat (gap) @(posedge mclk);
  endtask : step

  task automatic send(input logic [1:0] fmt, input int n, input logic neg, input int gap);
    for (int i = 0; i < n; i++) begin
      if (fmt == 2'h1) begin
        step(!neg, neg, gap);
        step(1'b0, 1'b0, gap);
      end else if (fmt == 2'h3) begin
        step(1'b0, neg, gap);
        step(1'b1, neg, gap);
        step(1'b0, neg, gap);
      end else begin
        // one quadrature cycle is four edges
        repeat (4) begin
          ph = neg ? ph - 2'h1 : ph + 2'h1;
          step(ph[1], ph[1] ^ ph[0], gap);
        end
      end
    end
    if (fmt == 2'h3) begin
      step(1'b0, 1'b0, gap);
    end
  endtask : send
endmodule : spci_ctl_model

// >>> tb/servo_pulse_command_io_tb.sv
`timescale 1ns/1ps

module servo_pulse_command_io_tb;
  logic mclk, rst, reg_wr, reg_rd, irq, probe1_pin, probe2_pin, fb_step, fb_dir, dr, ob;
  logic cmd_a_pin, cmd_b_pin, enc_a_out, enc_b_out, probe1_level, probe2_level;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cmd_pos, d;
  logic [31:0] fb_pos = 32'h0;
  logic [9:0] torque_limit_eff;
  logic [1:0] ecnt = 2'h0;
  int bad_count = 0, n_checks = 0, exp_pos = 0, dev_off = 0, acc = 0, pp, t1, tob, e, n, m;
  logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
    8'h24, 8'h28, 8'h2C, 8'h30};
  logic [31:0] rv [13] = '{32'h0, 32'h4E, 32'h0, 32'h9C4, 32'h01F4012C, 32'h1E, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h4E, 32'h12C, 32'h0};
  int th [4] = '{30, 30, 1, 1};
  int of [4] = '{30000, 30001, 1000, 1001};

  spci_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .cmd_a_pin(cmd_a_pin), .cmd_b_pin(cmd_b_pin), .probe1_pin(probe1_pin),
    .probe2_pin(probe2_pin), .fb_step(fb_step), .fb_dir(fb_dir), .fb_pos(fb_pos),
    .cmd_pos(cmd_pos), .torque_limit_eff(torque_limit_eff), .enc_a_out(enc_a_out),
    .enc_b_out(enc_b_out), .probe1_level(probe1_level), .probe2_level(probe2_level));
  spci_ctl_model ctl (.mclk(mclk), .pin_a(cmd_a_pin), .pin_b(cmd_b_pin));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Feedback follows the expected command so only dev_off creates deviation
  always @(posedge mclk) fb_pos <= 32'(exp_pos + dev_off);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, msg, got, want);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] want, input string msg);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    if (msg != "") chk(d, want, msg);
  endtask : rdchk

  task automatic cfg(input logic di, input logic [1:0] f, input logic [3:0] md, input logic b);
    wr(8'h04, {24'h0, b, md, f, di});
    wr(8'h00, 32'h1);
    repeat (4) @(posedge mclk);
  endtask : cfg

  task automatic fbs(input logic dir, input int gap);
    @(posedge mclk);
    fb_step <= 1'b1;
    fb_dir <= dir;
    @(posedge mclk);
    fb_step <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask : fbs

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask : endt

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, probe1_pin, probe2_pin, fb_step, fb_dir} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    void'($urandom(81));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    wr(8'h2C, 32'h0);
    foreach (ra[i]) rdchk(ra[i], rv[i], "reset value");
    endt("reset");
    wr(8'h04, 32'h0);
    ctl.send(2'h0, 2, 1'b0, 5);
    repeat (8) @(posedge mclk);
    chk(cmd_pos, 32'(exp_pos), "count before restart");
    rdchk(8'h28, 32'h4E, "active before restart");
    wr(8'h00, 32'h1);
    rdchk(8'h28, 32'h0, "active after restart");
    endt("restart");
    for (int f = 0; f < 4; f++) begin
      cfg(1'b0, 2'(f), 4'h0, 1'b0);
      n = 1 + $urandom % 3;
      m = $urandom % 3;
      ctl.send(2'(f), n, 1'b0, 5);
      ctl.send(2'(f), m, 1'b1, 5);
      exp_pos += ((f % 2 == 0) ? 4 : 1) * (n - m);
      repeat (8) @(posedge mclk);
      chk(cmd_pos, 32'(exp_pos), "format count");
    end
    rdchk(8'h24, 32'(exp_pos), "position register");
    endt("formats");
    for (int k = 0; k < 4; k++) begin
      wr(8'h18, 32'(k / 2));
      cfg(1'(k % 2), 2'h3, 4'h0, 1'b0);
      n = 1 + $urandom % 3;
      ctl.send(2'h3, n, 1'b0, 5);
      exp_pos += (k == 0) ? n : -n;
      repeat (8) @(posedge mclk);
      chk(cmd_pos, 32'(exp_pos), "direction sign");
    end
    endt("direction");
    for (int f = 0; f < 4; f++) begin
      cfg(1'b0, 2'(f), 4'h9, 1'b0);
      probe1_pin <= 1'($urandom);
      probe2_pin <= 1'($urandom);
      repeat (10) @(posedge mclk);
      chk({31'h0, probe1_level}, {31'h0, probe1_pin ^ (f % 2 == 0)}, "probe 1");
      chk({31'h0, probe2_level}, {31'h0, probe2_pin ^ (f < 2)}, "probe 2");
    end
    endt("probes");
    for (int k = 0; k < 16; k++) begin
      if (k % 8 == 0) begin
        pp = (k == 0) ? 16384 : 32768;
        ob = (k != 0);
        wr(8'h0C, 32'(pp));
        cfg(1'b0, 2'h3, 4'h9, ob);
      end
      dr = 1'($urandom);
      fbs(dr, 12);
      acc += pp * 4;
      if (acc >= 131072) begin
        acc -= 131072;
        ecnt = dr ? ecnt - 2'h1 : ecnt + 2'h1;
      end
      chk({30'h0, enc_a_out, enc_b_out}, {30'h0, ecnt[1], ecnt[1] ^ ecnt[0] ^ ob}, "phases");
    end
    fbs(1'b0, 8);
    fbs(1'b0, 12);
    rdchk(8'h1C, 32'h0, "no overspeed");
    fbs(1'b0, 2);
    fbs(1'b0, 12);
    rdchk(8'h1C, 32'h0, "");
    chk({31'h0, d[1]}, 32'h1, "overspeed flag");
    wr(8'h20, 32'h2);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "irq on overspeed");
    wr(8'h1C, 32'h2);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    endt("encoder");
    for (int i = 0; i < 6; i++) begin
      t1 = (i == 0) ? 600 : $urandom % 520;
      tob = $urandom % 501;
      wr(8'h10, 32'((tob << 16) | t1));
      e = (t1 > 500) ? 500 : t1;
      if (tob < e) e = tob;
      repeat (2) @(posedge mclk);
      chk({22'h0, torque_limit_eff}, 32'(e), "torque limit");
    end
    endt("torque");
    for (int i = 0; i < 4; i++) begin
      dev_off = 0;
      wr(8'h14, 32'(th[i]));
      repeat (3) @(posedge mclk);
      wr(8'h1C, 32'h3);
      dev_off = of[i];
      repeat (4) @(posedge mclk);
      rdchk(8'h1C, 32'h0, "");
      chk({31'h0, d[0]}, 32'(i % 2), "deviation alarm");
    end
    wr(8'h20, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "irq on deviation");
    dev_off = 0;
    repeat (3) @(posedge mclk);
    wr(8'h1C, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    endt("deviation");
    summarize();
  end
endmodule : servo_pulse_command_io_tb
